// *** led_pwm_pkg.sv ***
// Purpose: Constants for the LED PWM intensity block
// Assumes: Register writes arrive as address/data strobes from the host side
// Notes: Offsets are the register address codes
package led_pwm_pkg;
   localparam logic [7:0] ADDR_MASTER = 8'h0E;
   localparam logic [7:0] ADDR_INT0 = 8'h10;
   localparam logic [7:0] ADDR_INT3 = 8'h13;
   localparam logic [7:0] RST_MASTER = 8'h00;
   localparam logic [7:0] RST_INT = 8'hFF;
   localparam int MASTER_HI = 7;
   localparam int MASTER_LO = 4;
   localparam int NINTH_HI = 3;
   localparam int NINTH_LO = 0;
   localparam logic [3:0] FULL_SCALE = 4'hF;
   localparam logic [3:0] CYCLE_LAST = 4'hF;
   localparam logic [3:0] SLOT_LAST = 4'hE;
   localparam int OSC_HZ = 32000;
   localparam int CLK_HZ = 50000000;
   localparam int OSC_DIV = CLK_HZ / OSC_HZ;
   localparam int NUM_OUT = 9;
endpackage

// *** led_pwm_intensity_control.sv ***
// Purpose: PWM intensity generation for eight port outputs and a ninth output
// Assumes: Register file writes are presented as a one-cycle strobe
// Notes: Outputs are open drain; drive enable high pulls the pin low
`timescale 1ns/1ns
module led_pwm_intensity_control
   import led_pwm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic global_en,
   input wire logic [7:0] phase_bits,
   input wire logic ninth_phase,
   output logic [8:0] out_drive_low,
   output logic [7:0] slot_idx,
   output logic [7:0] cycle_idx
);
   import led_pwm_pkg::*;

   // ************************************************************
   // Register file
   // ************************************************************
   logic [7:0] master_q, master_d;
   logic [7:0] intens_q [4];
   logic [7:0] intens_d [4];

   // Writes land on the addressed register only
   always_comb begin
      master_d = master_q;
      for (int i = 0; i < 4; i++) begin
         intens_d[i] = intens_q[i];
      end
      if (wr_en && wr_addr == ADDR_MASTER) begin
         master_d = wr_data;
      end
      for (int i = 0; i < 4; i++) begin
         if (wr_en && wr_addr == ADDR_INT0 + 8'(i)) begin
            intens_d[i] = wr_data;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         master_q <= RST_MASTER;
         for (int i = 0; i < 4; i++) begin
            intens_q[i] <= RST_INT;
         end
      end else begin
         master_q <= master_d;
         for (int i = 0; i < 4; i++) begin
            intens_q[i] <= intens_d[i];
         end
      end
   end

   // Readback of stored values; unmapped reads zero
   always_comb begin
      rd_data = 8'h00;
      if (rd_addr == ADDR_MASTER) begin
         rd_data = master_q;
      end else if (rd_addr >= ADDR_INT0 && rd_addr <= ADDR_INT3) begin
         rd_data = intens_q[rd_addr[1:0]];
      end
   end

   // ************************************************************
   // Timebase
   // ************************************************************
   logic [3:0] master_nib;
   logic [3:0] ninth_nib;
   logic pwm_on;
   logic [15:0] div_q, div_d;
   logic [3:0] cyc_q, cyc_d;
   logic [3:0] slot_q, slot_d;
   logic tick;

   assign master_nib = master_q[MASTER_HI:MASTER_LO];
   assign ninth_nib = master_q[NINTH_HI:NINTH_LO];
   assign pwm_on = master_nib != 4'h0;

   // Oscillator stands in as a divider; stopped to save power when off
   always_comb begin
      div_d = div_q;
      cyc_d = cyc_q;
      slot_d = slot_q;
      tick = 1'b0;
      if (!pwm_on) begin
         div_d = 16'h0000;
         cyc_d = 4'h0;
         slot_d = 4'h0;
      end else if (div_q == 16'(OSC_DIV - 1)) begin
         div_d = 16'h0000;
         tick = 1'b1;
      end else begin
         div_d = div_q + 16'h0001;
      end
      if (tick) begin
         cyc_d = cyc_q + 4'h1;
         if (cyc_q == CYCLE_LAST) begin
            slot_d = (slot_q == SLOT_LAST) ? 4'h0 : slot_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_q <= 16'h0000;
         cyc_q <= 4'h0;
         slot_q <= 4'h0;
      end else begin
         div_q <= div_d;
         cyc_q <= cyc_d;
         slot_q <= slot_d;
      end
   end

   assign slot_idx = {4'h0, slot_q};
   assign cycle_idx = {4'h0, cyc_q};

   // ************************************************************
   // Output generation
   // ************************************************************
   logic [3:0] setting [NUM_OUT];
   logic [NUM_OUT-1:0] level;
   logic [NUM_OUT-1:0] drv_d, drv_q;
   logic slot_open;

   assign level = {ninth_phase, phase_bits};
   assign slot_open = slot_q < master_nib;

   // Intensity selection and per-output waveform
   always_comb begin
      for (int i = 0; i < NUM_OUT; i++) begin
         if (global_en) begin
            setting[i] = ninth_nib;
         end else if (i == NUM_OUT - 1) begin
            setting[i] = ninth_nib;
         end else begin
            setting[i] = intens_q[i/2][(i%2)*4 +: 4];
         end
         // Static low on level 0, released on level 1
         drv_d[i] = !level[i];
         if (pwm_on && setting[i] != FULL_SCALE) begin
            if (!slot_open) begin
               drv_d[i] = level[i]; // Gated slot acts as zero on-time
            end else if (!level[i]) begin
               drv_d[i] = cyc_q <= setting[i];
            end else begin
               drv_d[i] = cyc_q > setting[i];
            end
         end
      end
   end

   // Registered so pins never glitch on setting changes
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         drv_q <= '0;
      end else begin
         drv_q <= drv_d;
      end
   end

   assign out_drive_low = drv_q;

   // Assertions on the registered pins and the timebase
   a_static_off:
      assert property (@(posedge clk_sys) disable iff (rst)
      !pwm_on |=> out_drive_low == ~$past(level))
      else $error("static output wrong with master off");
   a_full_scale:
      assert property (@(posedge clk_sys) disable iff (rst)
      (!global_en && intens_q[0][3:0] == FULL_SCALE)
      |=> out_drive_low[0] == !$past(phase_bits[0]))
      else $error("full scale output not static");
   // Wrap alone needs a full period, so every slot step is watched
   a_slot_wrap:
      assert property (@(posedge clk_sys) disable iff (rst)
      (tick && cyc_q == CYCLE_LAST)
      |=> slot_q == (($past(slot_q) == SLOT_LAST) ? 4'h0
                     : $past(slot_q) + 4'h1))
      else $error("slot did not step or wrap after sixteen cycles");
   a_slot_range:
      assert property (@(posedge clk_sys) disable iff (rst)
      slot_q <= SLOT_LAST)
      else $error("slot index beyond last slot");
   a_halt_count:
      assert property (@(posedge clk_sys) disable iff (rst)
      !pwm_on |=> cyc_q == 4'h0 && slot_q == 4'h0)
      else $error("counters run while master off");
   a_low_duty:
      assert property (@(posedge clk_sys) disable iff (rst)
      (pwm_on && slot_open && global_en && ninth_nib != FULL_SCALE
       && !phase_bits[0])
      |=> out_drive_low[0] == ($past(cyc_q) <= $past(ninth_nib)))
      else $error("low duty wrong");
   a_high_duty:
      assert property (@(posedge clk_sys) disable iff (rst)
      (pwm_on && slot_open && !global_en && intens_q[1][7:4] != FULL_SCALE
       && phase_bits[3])
      |=> out_drive_low[3] == ($past(cyc_q) > $past(intens_q[1][7:4])))
      else $error("inverted duty wrong");
   a_gate_closed:
      assert property (@(posedge clk_sys) disable iff (rst)
      (pwm_on && !slot_open && ninth_nib != FULL_SCALE)
      |=> out_drive_low[8] == $past(ninth_phase))
      else $error("closed slot not gated");
   a_ninth_src:
      assert property (@(posedge clk_sys) disable iff (rst)
      (!pwm_on || ninth_nib == FULL_SCALE)
      |=> out_drive_low[8] == !$past(ninth_phase))
      else $error("ninth output level wrong");
endmodule

// *** led_pwm_host.sv ***
// Purpose: Host model that writes and reads the intensity registers
// Assumes: One write strobe per clock, readback is combinational
// Notes: Write data is inverted once released so stale values show
`timescale 1ns/1ns
module led_pwm_host (
   input wire logic clk_sys,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   output logic [7:0] rd_addr,
   input wire logic [7:0] rd_data
);
   // Idle bus at time zero
   initial begin
      wr_en = 1'b0;
      wr_addr = 8'h00;
      wr_data = 8'h00;
      rd_addr = 8'h00;
   end
   // One-cycle strobe; data lines not held once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      wr_data <= ~d;
   endtask
   // Address held a full cycle before readback is taken
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      rd_addr <= a;
      @(posedge clk_sys);
      d = rd_data;
   endtask
endmodule

// *** led_pwm_intensity_control_bench.sv ***
// Purpose: Self-checking bench for the PWM intensity block
// Assumes: One PWM step is OSC_DIV clocks; master slots all open at 0xF
// Notes: Duty measured by sampling mid-step over 16 steps
`timescale 1ns/1ns
module led_pwm_intensity_control_bench;
   import led_pwm_pkg::*;
   logic clk_sys, rst, wr_en, global_en, ninth_phase;
   logic [7:0] wr_addr, wr_data, rd_addr, rd_data, phase_bits, v;
   logic [7:0] slot_idx, cycle_idx;
   logic [8:0] drv, e;
   int error_cnt = 0;
   int compares = 0;
   int cnt[9];
   led_pwm_intensity_control i_dut (.clk_sys(clk_sys), .rst(rst),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_addr(rd_addr), .rd_data(rd_data), .global_en(global_en),
      .phase_bits(phase_bits), .ninth_phase(ninth_phase),
      .out_drive_low(drv), .slot_idx(slot_idx), .cycle_idx(cycle_idx));
   led_pwm_host i_host (.clk_sys(clk_sys), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
      .rd_data(rd_data));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic check(string nm, logic [8:0] seen, logic [8:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (error_cnt == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic rdchk(logic [7:0] a, logic [7:0] e);
      i_host.rd(a, v);
      check("rd_data", {1'b0, v}, {1'b0, e});
   endtask
   // Low steps expected in one cycle; 0xF lands on 16 or 0 by itself
   function automatic logic [8:0] lows(logic [3:0] n, logic ph);
      return ph ? 9'(15 - n) : 9'(n + 1);
   endfunction
   // Sample each output mid-step for 16 steps, bounded waits
   task automatic measure();
      logic [7:0] c;
      int k;
      cnt = '{default: 0};
      for (int s = 0; s < 16; s++) begin
         c = cycle_idx;
         k = 0;
         while (cycle_idx === c && k < 2 * OSC_DIV) begin
            @(posedge clk_sys);
            k++;
         end
         if (k >= 2 * OSC_DIV) begin
            error_cnt++;
            wrap_up();
         end
         repeat (OSC_DIV / 2) @(posedge clk_sys);
         for (int j = 0; j < 9; j++)
            cnt[j] += int'(drv[j] === 1'b1);
      end
   endtask
   // ******************************
   // Main sequence
   // ******************************
   initial begin
      rst = 1'b1;
      global_en = 1'b0;
      phase_bits = 8'hAA;
      ninth_phase = 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      rdchk(ADDR_MASTER, RST_MASTER);
      rdchk(ADDR_INT3, RST_INT);
      rdchk(8'h0F, 8'h00);
      for (int r = 0; r < 4; r++)
         i_host.wr(8'(ADDR_INT0 + r), 8'h00);
      i_host.wr(ADDR_MASTER, 8'h0A);
      global_en <= 1'b1;
      repeat (2000) @(posedge clk_sys);
      check("static", drv, 9'h055);
      check("cycle", {1'b0, cycle_idx}, 9'h000);
      // Mixed static and PWM outputs, individual control
      global_en <= 1'b0;
      ninth_phase <= 1'b0;
      i_host.wr(ADDR_INT0, 8'h50);
      i_host.wr(8'h11, 8'hEF);
      i_host.wr(8'h12, 8'h73);
      i_host.wr(ADDR_INT3, 8'hF0);
      i_host.wr(ADDR_MASTER, 8'hF3);
      rdchk(ADDR_MASTER, 8'hF3);
      measure();
      check("slot", {1'b0, slot_idx}, 9'h001);
      // Nibbles of registers 0x13..0x10 as one word, output 0 lowest
      for (int j = 0; j < 8; j++) begin
         e = lows(4'(32'hF073_EF50 >> (4 * j)), j % 2 == 1);
         check("duty", 9'(cnt[j]), e);
      end
      check("ninth", 9'(cnt[8]), 9'd4);
      // Global control, individual registers ignored
      global_en <= 1'b1;
      i_host.wr(ADDR_MASTER, 8'hF4);
      measure();
      for (int j = 0; j < 9; j++) begin
         e = (j % 2 == 1 && j < 8) ? 9'd11 : 9'd5;
         check("global", 9'(cnt[j]), e);
      end
      // Slot 2 lies beyond a master nibble of 1, so it is closed
      i_host.wr(ADDR_MASTER, 8'h14);
      repeat (3) @(posedge clk_sys);
      check("slot", {1'b0, slot_idx}, 9'h002);
      check("gated", drv, 9'h0AA);
      // Full scale ignores the closed slot and follows the phase bits
      i_host.wr(ADDR_MASTER, 8'h1F);
      repeat (3) @(posedge clk_sys);
      check("full", drv, 9'h155);
      wrap_up();
   end
endmodule
